// ### rtl/sdc_params.svh
// constants for the skew delay code control block
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH
`define SDC_CODE_W        6
`define SDC_CODE_MAX      6'h3F
`define SDC_STEP_PS       800
`define SDC_CODE_RESET    6'h00
`define SDC_CH_RED        2'h0
`define SDC_CH_GREEN      2'h1
`define SDC_CH_BLUE       2'h2
`define SDC_CH_NONE       2'h3
`define SDC_DIR_WRITE     1'b0
`define SDC_DIR_READ      1'b1
`define SDC_I2C_BASE      5'h0E
`define SDC_DIR_BIT       7
`define SDC_BYTE_BITS     4'h8
`endif

// ### rtl/sdc_pkg.sv
// types for the skew delay code control block
package sdc_pkg;
    typedef enum logic [3:0] {
        SDC_MODE_SLEEP  = 4'b0001,
        SDC_MODE_I2C    = 4'b0010,
        SDC_MODE_SPI    = 4'b0100,
        SDC_MODE_ANALOG = 4'b1000
    } sdc_mode_e;

    typedef enum logic [4:0] {
        SDC_I2C_IDLE  = 5'b00001,
        SDC_I2C_RECV  = 5'b00010,
        SDC_I2C_ACK   = 5'b00100,
        SDC_I2C_SEND  = 5'b01000,
        SDC_I2C_RACK  = 5'b10000
    } sdc_i2c_e;
endpackage

// ### rtl/sdc_top.sv
// skew delay code control: mode select, spi and i2c slave, code registers
`timescale 1ns/1ps
`default_nettype none
`include "sdc_params.svh"

// Summary of operation
// - sleep input low forces power-down whatever the other mode pins say.
// - sleep high with mode low takes delay codes from the serial bus.
// - digital control uses spi when select is high, i2c when low.
// - mode high uses analog digitised codes and ignores serial select.
// - each channel code is an unsigned six-bit value 0 to 63.
// - channel delay equals code times 0.8 ns steps.
// - code zero selects only the common fixed propagation delay.
// - one control option applies to all three channels together.
// - analog voltages become binary codes from the internal converter.
// - power-down saves power but never floats the video outputs.
// - direction bit zero writes a register, one reads it back.
// - select 00 red, 01 green, 10 blue.
// - spi is two bytes msb first on rising clock edges.
// - i2c address is base 0x38 plus two strap bits.
// - i2c write three bytes; read four with repeated address.
module sdc_top
    import sdc_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       sleep_input_i,
    input  wire logic       control_mode_i,
    input  wire logic       serial_bus_select_i,
    input  wire logic [5:0] red_adc_code_i,
    input  wire logic [5:0] green_adc_code_i,
    input  wire logic [5:0] blue_adc_code_i,
    input  wire logic       bus_clk_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       sdi_strap_high_i,
    input  wire logic       sda_i,
    output logic            sdo_sda_o,
    output logic            sdo_sda_oe_n_o,
    output logic            powered_o,
    output logic [5:0]      red_delay_o,
    output logic [5:0]      green_delay_o,
    output logic [5:0]      blue_delay_o,
    output sdc_mode_e       mode_o
);

    // ------------------------------------------------------------
    // mode select, system domain
    // ------------------------------------------------------------
    logic [1:0] sync_sleep;
    logic [1:0] sync_mode;
    logic [1:0] sync_sel;
    logic [5:0] sync_r1, sync_r2, sync_g1, sync_g2, sync_b1, sync_b2;
    sdc_mode_e  next_mode;

    always_ff @(posedge clock_i) begin
        sync_sleep <= {sync_sleep[0], sleep_input_i};
        sync_mode  <= {sync_mode[0], control_mode_i};
        sync_sel   <= {sync_sel[0], serial_bus_select_i};
        sync_r1    <= red_adc_code_i;
        sync_r2    <= sync_r1;
        sync_g1    <= green_adc_code_i;
        sync_g2    <= sync_g1;
        sync_b1    <= blue_adc_code_i;
        sync_b2    <= sync_b1;
    end

    assign next_mode = !sync_sleep[1] ? SDC_MODE_SLEEP :
                       sync_mode[1]   ? SDC_MODE_ANALOG :
                       sync_sel[1]    ? SDC_MODE_SPI : SDC_MODE_I2C;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mode_o <= SDC_MODE_SLEEP;
        end else begin
            mode_o <= next_mode;
        end
    end

    // mode handed to link domain as a level, two flops
    logic [1:0] lk_spi_s, lk_i2c_s;
    wire        is_spi_mode = (mode_o == SDC_MODE_SPI);
    wire        is_i2c_mode = (mode_o == SDC_MODE_I2C);

    always_ff @(posedge bus_clk_i) begin
        lk_spi_s <= {lk_spi_s[0], is_spi_mode};
        lk_i2c_s <= {lk_i2c_s[0], is_i2c_mode};
    end

    // ------------------------------------------------------------
    // code registers, link domain
    // ------------------------------------------------------------
    logic [5:0] code_reg [0:2];
    logic       wr_en;
    logic [1:0] wr_ch;
    logic [5:0] wr_code;
    logic [1:0] rd_ch;
    wire  [5:0] rd_code = (rd_ch == `SDC_CH_NONE) ? `SDC_CODE_RESET : code_reg[rd_ch];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_code
            always_ff @(posedge bus_clk_i) begin
                if (sys_rst_i) begin
                    code_reg[gi] <= `SDC_CODE_RESET;
                end else if (wr_en && wr_ch == 2'(gi)) begin
                    code_reg[gi] <= wr_code;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // spi slave, bus clock
    // ------------------------------------------------------------
    logic [3:0] spi_cnt;
    logic [7:0] spi_sh;
    logic       spi_dir;
    logic [1:0] spi_ch;
    logic [5:0] spi_out;
    logic       spi_wr;
    wire        spi_act = lk_spi_s[1] && !spi_cs_n_i;

    always_ff @(posedge bus_clk_i) begin
        spi_wr <= 1'b0;
        if (sys_rst_i || !spi_act) begin
            spi_cnt <= 4'h0;
        end else begin
            spi_sh  <= {spi_sh[6:0], sdi_strap_high_i};
            spi_cnt <= spi_cnt + 4'h1;
            if (spi_cnt == 4'h7) begin
                spi_dir <= spi_sh[6];
                spi_ch  <= {spi_sh[0], sdi_strap_high_i};
                spi_out <= code_reg[{spi_sh[0], sdi_strap_high_i} == `SDC_CH_NONE ?
                                    2'h0 : {spi_sh[0], sdi_strap_high_i}];
            end else if (spi_cnt == 4'hF) begin
                spi_wr  <= (spi_dir == `SDC_DIR_WRITE);
            end else if (spi_cnt >= 4'hA) begin
                // shift only once D5 has been shown, so bit slot 10 carries D5
                spi_out <= {spi_out[4:0], 1'b0};
            end
            if (spi_cnt == 4'hF) begin
                spi_sh <= {spi_sh[6:0], sdi_strap_high_i};
            end
        end
    end

    wire spi_sdo = (spi_cnt >= 4'hA) ? spi_out[5] : 1'b0;

    // ------------------------------------------------------------
    // i2c slave, sampled on scl rising edge of bus clock
    // ------------------------------------------------------------
    sdc_i2c_e   i2c_st;
    logic [3:0] i2c_bit;
    logic [7:0] i2c_sh;
    logic [1:0] i2c_byte;
    logic [1:0] i2c_ch;
    logic       i2c_read;
    logic       i2c_rs;
    logic       i2c_wr;
    logic       sda_q;
    logic [1:0] strap_low_s, strap_high_s;
    wire  [6:0] my_addr = {`SDC_I2C_BASE, strap_high_s[1], strap_low_s[1]};
    wire  [7:0] rx_byte = {i2c_sh[6:0], sda_i};
    wire        addr_hit = rx_byte[7:1] == my_addr;

    always_ff @(posedge bus_clk_i) begin
        strap_low_s  <= {strap_low_s[0], spi_cs_n_i};
        strap_high_s <= {strap_high_s[0], sdi_strap_high_i};
    end

    // start condition restarts framing: sda falls while clock high
    logic start_seen;
    always_ff @(negedge sda_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_seen <= 1'b0;
        end else if (bus_clk_i) begin
            // toggle, so every start shows up as a change
            start_seen <= ~start_seen;
        end
    end
    logic start_q;
    wire  start_evt = start_seen ^ start_q;
    always_ff @(posedge bus_clk_i) begin
        start_q <= start_seen;
    end

    always_ff @(posedge bus_clk_i) begin
        i2c_wr <= 1'b0;
        if (sys_rst_i || !lk_i2c_s[1]) begin
            i2c_st   <= SDC_I2C_IDLE;
            i2c_bit  <= 4'h0;
            i2c_byte <= 2'h0;
            i2c_rs   <= 1'b0;
            sda_q    <= 1'b1;
        end else begin
            if (start_evt) begin
                // the edge after a start already carries the first bit
                i2c_st   <= SDC_I2C_RECV;
                i2c_sh   <= rx_byte;
                i2c_bit  <= 4'h1;
                sda_q    <= 1'b1;
                // a start after the channel byte is the repeated start of a read
                i2c_rs   <= (i2c_byte == 2'h2);
                i2c_byte <= (i2c_byte == 2'h2) ? 2'h2 : 2'h0;
            end else begin
            case (i2c_st)
            SDC_I2C_IDLE: begin
                sda_q <= 1'b1;
            end
            SDC_I2C_RECV: begin
                sda_q   <= 1'b1;
                i2c_sh  <= rx_byte;
                i2c_bit <= i2c_bit + 4'h1;
                if (i2c_bit == 4'h7) begin
                    i2c_bit <= 4'h0;
                    if (i2c_byte == 2'h0 || (i2c_byte == 2'h2 && i2c_rs)) begin
                        i2c_read <= rx_byte[0];
                        if (addr_hit) begin
                            i2c_st <= SDC_I2C_ACK;
                            sda_q  <= 1'b0;
                        end else begin
                            i2c_st <= SDC_I2C_IDLE;
                        end
                    end else begin
                        if (i2c_byte == 2'h1) begin
                            i2c_ch <= rx_byte[1:0];
                        end else begin
                            i2c_wr <= !i2c_read;
                        end
                        i2c_st <= SDC_I2C_ACK;
                        sda_q  <= 1'b0;
                    end
                end
            end
            SDC_I2C_ACK: begin
                i2c_byte <= i2c_byte + 2'h1;
                if (i2c_read && i2c_byte == 2'h2) begin
                    i2c_st <= SDC_I2C_SEND;
                    // top two bits of the returned byte are zero
                    sda_q  <= 1'b0;
                end else begin
                    i2c_st <= SDC_I2C_RECV;
                    sda_q  <= 1'b1;
                end
            end
            SDC_I2C_SEND: begin
                i2c_bit <= i2c_bit + 4'h1;
                sda_q   <= (i2c_bit == 4'h0 || i2c_bit == 4'h7) ? (i2c_bit == 4'h7) :
                           rd_code[3'(4'h6 - i2c_bit)];
                if (i2c_bit == 4'h7) begin
                    i2c_st <= SDC_I2C_RACK;
                end
            end
            SDC_I2C_RACK: begin
                i2c_st   <= SDC_I2C_IDLE;
                i2c_byte <= 2'h0;
            end
            default: i2c_st <= SDC_I2C_IDLE;
            endcase
            end
        end
    end

    // ------------------------------------------------------------
    // write port mux and i2c read select
    // ------------------------------------------------------------
    assign wr_en   = (spi_wr || i2c_wr) &&
                     ((spi_wr ? spi_ch : i2c_ch) != `SDC_CH_NONE);
    assign wr_ch   = spi_wr ? spi_ch : i2c_ch;
    assign wr_code = spi_wr ? spi_sh[5:0] : i2c_sh[5:0];
    assign rd_ch   = i2c_ch;

    logic spi_oe_n;
    logic sda_drive_n;

    always_ff @(posedge bus_clk_i) begin
        if (sys_rst_i) begin
            sdo_sda_o <= 1'b0;
            spi_oe_n  <= 1'b1;
        end else if (lk_spi_s[1]) begin
            sdo_sda_o <= spi_sdo;
            spi_oe_n  <= spi_cs_n_i;
        end else begin
            sdo_sda_o <= 1'b0;
            spi_oe_n  <= 1'b1;
        end
    end

    // ack and read bits change on the falling clock, stand over the high phase
    always_ff @(negedge bus_clk_i) begin
        if (sys_rst_i) begin
            sda_drive_n <= 1'b1;
        end else begin
            sda_drive_n <= sda_q;
        end
    end

    assign sdo_sda_oe_n_o = lk_spi_s[1] ? spi_oe_n : sda_drive_n;

    // ------------------------------------------------------------
    // codes back to system domain; values are quasi-static
    // ------------------------------------------------------------
    logic [5:0] cr1, cr2, cg1, cg2, cb1, cb2;
    always_ff @(posedge clock_i) begin
        cr1 <= code_reg[0];
        cr2 <= cr1;
        cg1 <= code_reg[1];
        cg2 <= cg1;
        cb1 <= code_reg[2];
        cb2 <= cb1;
    end

    // delay = code * 0.8 ns; zero leaves only the fixed path delay
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            red_delay_o   <= `SDC_CODE_RESET;
            green_delay_o <= `SDC_CODE_RESET;
            blue_delay_o  <= `SDC_CODE_RESET;
            powered_o     <= 1'b0;
        end else begin
            powered_o <= (next_mode != SDC_MODE_SLEEP);
            if (next_mode == SDC_MODE_ANALOG) begin
                red_delay_o   <= sync_r2;
                green_delay_o <= sync_g2;
                blue_delay_o  <= sync_b2;
            end else if (next_mode != SDC_MODE_SLEEP) begin
                red_delay_o   <= cr2;
                green_delay_o <= cg2;
                blue_delay_o  <= cb2;
            end
        end
    end

endmodule // sdc_top
`default_nettype wire

// ### tb/sdc_spi_master.sv
// spi bus master model for the skew delay code block
`timescale 1ns/1ps
`default_nettype none
module sdc_spi_master (
    input  wire logic sdo_i,
    input  wire logic sda_i,
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    output logic      sda_o
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
        sda_o = 1'b1;
    end
    // i2c start with straps a1=0 a0=1
    task automatic i2c_start();
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
        sda_o = 1'b1;
        #16 sck_o = 1'b1;
        #16 sda_o = 1'b0;
        #16 sck_o = 1'b0;
        #16;
    endtask
    // eight bits msb first, then the ninth clock with sda released
    task automatic i2c_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_o = (i == 0) ? 1'b1 : tx[i-1];
            #16 sck_o = 1'b1;
            #16;
            if (i == 0) ack = sda_i;
            else rx[i-1] = sda_i;
            #16 sck_o = 1'b0;
            #16;
        end
    endtask
    // free clock pulses, used while reset is held and to carry the spi mode into the link domain
    task automatic pulses(input int n);
        repeat (n) begin
            sck_o = 1'b1;
            #32 sck_o = 1'b0;
            #32;
        end
    endtask
    // one frame msb first, sdo caught mid high phase
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi_o = tx[i];
            #32 sck_o = 1'b1;
            #16 rx[i] = sdo_i;
            #16 sck_o = 1'b0;
        end
        #32 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        // tail edge lets the frame apply
        #32 sck_o = 1'b1;
        #32 sck_o = 1'b0;
    endtask
endmodule // sdc_spi_master
`default_nettype wire

// ### tb/sdc_checker_asserts.sv
// concurrent checks on the skew delay code block ports
`timescale 1ns/1ps
`default_nettype none
module sdc_checker
    import sdc_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       sys_rst_i,
    input wire logic       sleep_input_i,
    input wire logic       control_mode_i,
    input wire logic       serial_bus_select_i,
    input wire logic [5:0] red_adc_code_i,
    input wire logic [5:0] green_adc_code_i,
    input wire logic [5:0] blue_adc_code_i,
    input wire logic       powered_o,
    input wire logic [5:0] red_delay_o,
    input wire logic [5:0] green_delay_o,
    input wire logic [5:0] blue_delay_o,
    input wire sdc_mode_e  mode_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    sleep_wins_a: assert property (!sleep_input_i [*5] |-> mode_o == SDC_MODE_SLEEP)
        else $error("mode not sleep while sleep input low");
    spi_select_a: assert property ((sleep_input_i && !control_mode_i && serial_bus_select_i) [*5]
        |-> mode_o == SDC_MODE_SPI) else $error("spi mode not taken");
    i2c_select_a: assert property ((sleep_input_i && !control_mode_i && !serial_bus_select_i) [*5]
        |-> mode_o == SDC_MODE_I2C) else $error("i2c mode not taken");
    analog_select_a: assert property ((sleep_input_i && control_mode_i) [*5]
        |-> mode_o == SDC_MODE_ANALOG) else $error("analog mode not taken");
    analog_codes_a: assert property ((mode_o == SDC_MODE_ANALOG && $stable(red_adc_code_i)
        && $stable(green_adc_code_i) && $stable(blue_adc_code_i)) [*5] |-> red_delay_o ==
        red_adc_code_i && green_delay_o == green_adc_code_i && blue_delay_o == blue_adc_code_i)
        else $error("analog codes not applied");
    sleep_hold_a: assert property ((mode_o == SDC_MODE_SLEEP) [*3] |-> $stable(red_delay_o)
        && $stable(green_delay_o) && $stable(blue_delay_o)) else $error("codes moved in sleep");
    power_off_a: assert property ((mode_o == SDC_MODE_SLEEP) [*2] |-> !powered_o)
        else $error("powered in sleep");
    power_on_a: assert property ((mode_o != SDC_MODE_SLEEP) [*2] |-> powered_o)
        else $error("not powered when awake");
    mode_onehot_a: assert property ($onehot(mode_o)) else $error("mode not one-hot");
    cover property (mode_o == SDC_MODE_SPI);
    cover property (mode_o == SDC_MODE_ANALOG);
    cover property ($fell(powered_o));
endmodule // sdc_checker
bind sdc_top sdc_checker i_sdc_checker (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .sleep_input_i(sleep_input_i), .control_mode_i(control_mode_i),
    .serial_bus_select_i(serial_bus_select_i), .red_adc_code_i(red_adc_code_i),
    .green_adc_code_i(green_adc_code_i), .blue_adc_code_i(blue_adc_code_i),
    .powered_o(powered_o), .red_delay_o(red_delay_o), .green_delay_o(green_delay_o),
    .blue_delay_o(blue_delay_o), .mode_o(mode_o));
`default_nettype wire

// ### tb/skew_delay_code_control_bench.sv
// self-checking bench for the skew delay code block
`timescale 1ns/1ps
`default_nettype none
module skew_delay_code_control_bench;
    import sdc_pkg::*;
    typedef struct packed {logic sl; logic md; logic ss; sdc_mode_e m;} sdc_row_s;
    logic       clock_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       sleep_i = 1'b0, ctl_i = 1'b0, sel_i = 1'b0;
    logic [5:0] adc_r = 6'h0A, adc_g = 6'h14, adc_b = 6'h23;
    logic [15:0] rx;
    logic [7:0] rb;
    logic       ack;
    wire logic  bclk, csn, sdi, sdo, oen, pwr, sda_m;
    wire logic  sda_line = sda_m & (oen | sdo);
    wire logic [5:0] r_o, g_o, b_o;
    sdc_mode_e  mode;
    int         fail_count = 0, comparisons = 0;
    sdc_row_s   rows [6] = '{'{0, 1, 1, SDC_MODE_SLEEP}, '{0, 0, 0, SDC_MODE_SLEEP},
        '{1, 0, 0, SDC_MODE_I2C}, '{1, 0, 1, SDC_MODE_SPI}, '{1, 1, 0, SDC_MODE_ANALOG},
        '{1, 1, 1, SDC_MODE_ANALOG}};
    sdc_top i_sdc_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .sleep_input_i(sleep_i),
        .control_mode_i(ctl_i), .serial_bus_select_i(sel_i), .red_adc_code_i(adc_r),
        .green_adc_code_i(adc_g), .blue_adc_code_i(adc_b), .bus_clk_i(bclk),
        .spi_cs_n_i(csn), .sdi_strap_high_i(sdi), .sda_i(sda_line), .sdo_sda_o(sdo),
        .sdo_sda_oe_n_o(oen), .powered_o(pwr), .red_delay_o(r_o), .green_delay_o(g_o),
        .blue_delay_o(b_o), .mode_o(mode));
    sdc_spi_master i_sdc_spi_master (.sdo_i(sdo), .sda_i(sda_line), .sck_o(bclk), .cs_n_o(csn),
        .mosi_o(sdi), .sda_o(sda_m));
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic spi(input logic rw, input logic [1:0] ch, input logic [5:0] code);
        i_sdc_spi_master.frame({rw, 5'h00, ch, 2'h0, code}, rx);
        repeat (10) @(negedge clock_i);
    endtask
    task automatic i2c(input logic [7:0] b, input logic exp_ack);
        i_sdc_spi_master.i2c_byte(b, rb, ack);
        check("i2c_ack", ack, exp_ack);
    endtask
    task automatic codes(input logic [5:0] r, input logic [5:0] g, input logic [5:0] b);
        check("red", r_o, r);
        check("green", g_o, g);
        check("blue", b_o, b);
    endtask
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
    initial begin
        #2;
        fork
            i_sdc_spi_master.pulses(2);
            repeat (8) @(negedge clock_i);
        join
        check("reset_mode", mode, SDC_MODE_SLEEP);
        check("reset_oe_n", oen, 1'b1);
        codes(6'h00, 6'h00, 6'h00);
        sys_rst_i = 1'b0;
        foreach (rows[i]) begin
            {sleep_i, ctl_i, sel_i} = {rows[i].sl, rows[i].md, rows[i].ss};
            repeat (8) @(negedge clock_i);
            check("mode", mode, rows[i].m);
            check("powered", pwr, rows[i].sl);
            if (rows[i].md && rows[i].sl) codes(adc_r, adc_g, adc_b);
        end
        sleep_i = 1'b0;
        repeat (8) @(negedge clock_i);
        codes(adc_r, adc_g, adc_b);
        {sleep_i, ctl_i, sel_i} = 3'b101;
        repeat (8) @(negedge clock_i);
        // idle clocks carry the spi mode into the link domain
        i_sdc_spi_master.pulses(3);
        // green longest cable gets code zero
        spi(1'b0, 2'h0, 6'h3F);
        spi(1'b0, 2'h1, 6'h00);
        spi(1'b0, 2'h2, 6'h23);
        codes(6'h3F, 6'h00, 6'h23);
        spi(1'b0, 2'h0, 6'h32);
        spi(1'b0, 2'h3, 6'h15);
        codes(6'h32, 6'h00, 6'h23);
        spi(1'b1, 2'h2, 6'h00);
        check("read_blue", rx[5:0], 6'h23);
        spi(1'b1, 2'h0, 6'h00);
        check("read_red", rx[5:0], 6'h32);
        codes(6'h32, 6'h00, 6'h23);
        sel_i = 1'b0;
        repeat (8) @(negedge clock_i);
        spi(1'b0, 2'h0, 6'h01);
        codes(6'h32, 6'h00, 6'h23);
        i_sdc_spi_master.i2c_start();
        i2c(8'h72, 1'b0);
        i2c(8'h01, 1'b0);
        i2c(8'h2A, 1'b0);
        repeat (10) @(negedge clock_i);
        codes(6'h32, 6'h2A, 6'h23);
        i_sdc_spi_master.i2c_start();
        i2c(8'h72, 1'b0);
        i2c(8'h02, 1'b0);
        i_sdc_spi_master.i2c_start();
        i2c(8'h73, 1'b0);
        i2c(8'hFF, 1'b1);
        check("i2c_read_blue", rb, 8'h23);
        i_sdc_spi_master.i2c_start();
        i2c(8'h70, 1'b1);
        wrap_up();
    end
endmodule // skew_delay_code_control_bench
`default_nettype wire
